//--- core/erb_defs.vh
`ifndef ERB_DEFS_VH
`define ERB_DEFS_VH

// Register byte offsets on the APB slave
`define ERB_ADDR_STATUS 8'h00
`define ERB_ADDR_RETPC_LO 8'h04
`define ERB_ADDR_RETPC_HI 8'h08
`define ERB_ADDR_ERRPC_LO 8'h0C
`define ERB_ADDR_ERRPC_HI 8'h10
`define ERB_ADDR_SHADOW 8'h14
`define ERB_ADDR_CONFIG 8'h18
`define ERB_ADDR_STATE 8'h1C

// Status register bit positions
`define ERB_ST_IE 0
`define ERB_ST_EXL 1
`define ERB_ST_ERL 2
`define ERB_ST_BEV 22
// Status after reset: boot vectors selected, error level set
`define ERB_STATUS_RST 32'h00400004

// Shadow set control field positions, each field 4 bits
`define ERB_SH_CSS_LSB 0
`define ERB_SH_PSS_LSB 6
`define ERB_SH_HSS_LSB 26

// Config word field positions
`define ERB_CF_REV_LSB 0
`define ERB_CF_COMP 4
`define ERB_CF_ISA_LSB 5
`define ERB_CF_NOCLR 8

// State word bit positions
`define ERB_SW_MODE 0
`define ERB_SW_LINK 1
`define ERB_SW_BUSY 2

// Instruction encodings
`define ERB_ENC_BARRIER 32'h00001800
`define ERB_ENC_RETURN 32'h0000F37C
`define ERB_ENC_RETURN_NC 32'h0001F37C
`define ERB_ENC_IRQEN 32'h0000577C
`define ERB_MASK_IRQEN 32'hFFE0FFFF

// Operation classes
`define ERB_CLS_NONE 3'h0
`define ERB_CLS_BARRIER 3'h1
`define ERB_CLS_IRQEN 3'h2
`define ERB_CLS_RETURN 3'h3
`define ERB_CLS_RETURN_NC 3'h4

`endif

//--- core/erb_unit.v
// Local design decisions: the placing of the registers and the APB register port.
`include "erb_defs.vh"

// Overview of operation
// [RULE_01] Barrier decodes as shift r0,r0 by 3
// [RULE_02] Barrier stalls issue until hazards clear
// [RULE_03] Barrier never clears instruction hazards
// [RULE_04] First release treats barrier as superscalar nop
// [RULE_05] Irq enable returns status, sets enable
// [RULE_06] Irq enable without cp0 access faults
// [RULE_07] Irq enable before release 2 reserved
// [RULE_08] Irq enable read-and-set is indivisible
// [RULE_09] Software clears irq hazard, no timing
// [RULE_10] Return has no delay slot
// [RULE_11] Error level return uses error pc
// [RULE_12] Otherwise normal pc, clear exception level
// [RULE_13] Conditionally restore shadow set on return
// [RULE_14] Target bit 0 selects instruction mode
// [RULE_15] Return clears link reservation
// [RULE_16] Both returns clear all hazards
// [RULE_17] No-clear return keeps link reservation
// [RULE_18] Config bit reports no-clear return
// [RULE_19] Delay slot restriction only before release 6; the code checks no delay slot on any release
// [RULE_20] Returns without cp0 access fault, no change
module erb_unit #(
	parameter [3:0] ARCH_REV = 4'h6,
	parameter [0:0] COMPRESSED_IMPL = 1'b1,
	parameter [1:0] ISA_SUPPORT = 2'h1,
	parameter [0:0] NOCLEAR_PRESENT = 1'b1,
	parameter [3:0] HIGHEST_SET = 4'h3
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire instr_valid,
	input wire [31:0] instr_word,
	input wire cp0_usable,
	input wire exec_hazard_busy,
	input wire load_linked,
	input wire store_conditional,
	output reg instr_ready,
	output reg op_done,
	output reg gpr_we,
	output reg [4:0] gpr_waddr,
	output reg [63:0] gpr_wdata,
	output reg redirect_valid,
	output reg [63:0] redirect_pc,
	output reg squash_next,
	output reg clear_instr_hazards,
	output reg superscalar_nop,
	output reg exc_cop_unusable,
	output reg exc_reserved,
	output reg global_irq_enable,
	output reg instr_set_mode,
	output reg link_reservation_flag
);

////////////////////////////////////////////////////////////////////////
// Constants and functions

// Issue states
localparam [0:0] ST_IDLE = 1'b0;
localparam [0:0] ST_WAIT = 1'b1;

// Classify an instruction word
function [2:0] erb_class;
	input [31:0] w;
	begin
		// [RULE_01] barrier encoding match
		if (w == `ERB_ENC_BARRIER) begin
			erb_class = `ERB_CLS_BARRIER;
		end else if ((w & `ERB_MASK_IRQEN) == `ERB_ENC_IRQEN) begin
			erb_class = `ERB_CLS_IRQEN;
		end else if (w == `ERB_ENC_RETURN) begin
			erb_class = `ERB_CLS_RETURN;
		end else if (w == `ERB_ENC_RETURN_NC) begin
			erb_class = `ERB_CLS_RETURN_NC;
		end else begin
			erb_class = `ERB_CLS_NONE;
		end
	end
endfunction

// Merge write data under byte strobes
function [31:0] erb_merge;
	input [31:0] old;
	input [31:0] wd;
	input [3:0] st;
	integer i;
	begin
		erb_merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (st[i]) begin
				erb_merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
// State

reg [0:0] state; // Issue state
reg [31:0] status; // Status word
reg [63:0] ret_pc; // Normal return address
reg [63:0] err_pc; // Error return address
reg [3:0] current_shadow_set; // Current shadow set
reg [3:0] previous_shadow_set; // Previous shadow set

wire [2:0] cls; // Class of offered word
wire take; // Word accepted this edge
wire apb_wr; // Write completes this edge
wire [31:0] sh_word; // Shadow control as read
wire [31:0] cfg_word; // Configuration as read
wire [31:0] state_word; // Live state as read
wire ret_ok; // Return may execute
wire irq_ok; // Irq enable may execute
wire [63:0] ret_tgt; // Selected return target
wire split_mode; // Target bit 0 is a mode bit
wire shadow_restore; // Shadow set copy allowed
reg [31:0] rd_mux; // Read data before register

assign cls = erb_class(instr_word);
assign take = instr_valid & instr_ready;
assign apb_wr = psel & penable & pready & pwrite;

assign sh_word = ({28'h0, current_shadow_set} << `ERB_SH_CSS_LSB) | ({28'h0, previous_shadow_set} << `ERB_SH_PSS_LSB)
	| ({28'h0, HIGHEST_SET} << `ERB_SH_HSS_LSB);
// [RULE_18] no-clear return presence bit
assign cfg_word = ({28'h0, ARCH_REV} << `ERB_CF_REV_LSB) | ({31'h0, COMPRESSED_IMPL} << `ERB_CF_COMP)
	| ({30'h0, ISA_SUPPORT} << `ERB_CF_ISA_LSB) | ({31'h0, NOCLEAR_PRESENT} << `ERB_CF_NOCLR);
assign state_word = ({31'h0, instr_set_mode} << `ERB_SW_MODE)
	| ({31'h0, link_reservation_flag} << `ERB_SW_LINK) | ({31'h0, state} << `ERB_SW_BUSY);

// [RULE_20] cp0 access gate for returns
assign ret_ok = cp0_usable & ~((cls == `ERB_CLS_RETURN_NC) & ~NOCLEAR_PRESENT);
// [RULE_07] release gate for irq enable
assign irq_ok = (ARCH_REV >= 4'h2) & cp0_usable;
// [RULE_11] error pc when error level set
assign ret_tgt = status[`ERB_ST_ERL] ? err_pc : ret_pc;
// [RULE_14] mode bit split condition
assign split_mode = COMPRESSED_IMPL | (ISA_SUPPORT != 2'h0);
// [RULE_13] shadow restore conditions
assign shadow_restore = (ARCH_REV >= 4'h2) & (HIGHEST_SET != 4'h0) & ~status[`ERB_ST_BEV];

////////////////////////////////////////////////////////////////////////
// APB read decode

// Unmapped offsets read zero and flag an error
always @* begin
	case (paddr)
		`ERB_ADDR_STATUS: rd_mux = status;
		`ERB_ADDR_RETPC_LO: rd_mux = ret_pc[31:0];
		`ERB_ADDR_RETPC_HI: rd_mux = ret_pc[63:32];
		`ERB_ADDR_ERRPC_LO: rd_mux = err_pc[31:0];
		`ERB_ADDR_ERRPC_HI: rd_mux = err_pc[63:32];
		`ERB_ADDR_SHADOW: rd_mux = sh_word;
		`ERB_ADDR_CONFIG: rd_mux = cfg_word;
		`ERB_ADDR_STATE: rd_mux = state_word;
		default: rd_mux = 32'h00000000;
	endcase
end

// Answer every access one cycle into the access phase
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end else begin
		pready <= psel & ~penable;
		pslverr <= 1'b0;
		if (psel & ~penable) begin
			// Setup cycle: latch the answer now
			prdata <= pwrite ? 32'h00000000 : rd_mux;
			pslverr <= (paddr[1:0] != 2'h0) | (paddr > `ERB_ADDR_STATE);
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Control register file

// Instruction effects are applied after software writes, so
// an instruction landing in the same edge as a write wins
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		status <= `ERB_STATUS_RST;
		ret_pc <= 64'h0000000000000000;
		err_pc <= 64'h0000000000000000;
		current_shadow_set <= 4'h0;
		previous_shadow_set <= 4'h0;
		instr_set_mode <= 1'b0;
		link_reservation_flag <= 1'b0;
	end else begin
		// Software writes
		if (apb_wr) begin
			case (paddr)
				`ERB_ADDR_STATUS: status <= erb_merge(status, pwdata, pstrb);
				`ERB_ADDR_RETPC_LO: ret_pc[31:0] <= erb_merge(ret_pc[31:0], pwdata, pstrb);
				`ERB_ADDR_RETPC_HI: ret_pc[63:32] <= erb_merge(ret_pc[63:32], pwdata, pstrb);
				`ERB_ADDR_ERRPC_LO: err_pc[31:0] <= erb_merge(err_pc[31:0], pwdata, pstrb);
				`ERB_ADDR_ERRPC_HI: err_pc[63:32] <= erb_merge(err_pc[63:32], pwdata, pstrb);
				`ERB_ADDR_SHADOW: begin
					if (pstrb[0]) begin
						current_shadow_set <= pwdata[`ERB_SH_CSS_LSB +: 4];
					end
					if (pstrb[0] | pstrb[1]) begin
						previous_shadow_set <= pwdata[`ERB_SH_PSS_LSB +: 4];
					end
				end
				default: begin
				end
			endcase
		end
		// Store-conditional consumes the reservation
		if (store_conditional) begin
			link_reservation_flag <= 1'b0;
		end
		// [RULE_08] read and set in one edge
		if (take & (cls == `ERB_CLS_IRQEN) & irq_ok) begin
			status[`ERB_ST_IE] <= 1'b1;
		end
		if (take & ((cls == `ERB_CLS_RETURN) | (cls == `ERB_CLS_RETURN_NC)) & ret_ok) begin
			if (status[`ERB_ST_ERL]) begin
				// [RULE_11] leave error level
				status[`ERB_ST_ERL] <= 1'b0;
			end else begin
				// [RULE_12] leave exception level
				status[`ERB_ST_EXL] <= 1'b0;
				// [RULE_13] shadow set restore
				if (shadow_restore) begin
					current_shadow_set <= previous_shadow_set;
				end
			end
			// [RULE_14] mode from target bit 0
			if (split_mode) begin
				instr_set_mode <= ret_tgt[0];
			end
			// [RULE_15] plain return drops reservation
			// [RULE_17] no-clear variant keeps it
			if (cls == `ERB_CLS_RETURN) begin
				link_reservation_flag <= 1'b0;
			end
		end
		// A new reservation wins over any clear in the same edge
		if (load_linked) begin
			link_reservation_flag <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Instruction execution

// Every answer is a one-cycle pulse one edge after the word is taken, save a stalled barrier's op_done, which waits for hazards to clear
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state <= ST_IDLE;
		instr_ready <= 1'b0;
		op_done <= 1'b0;
		gpr_we <= 1'b0;
		gpr_waddr <= 5'h00;
		gpr_wdata <= 64'h0000000000000000;
		redirect_valid <= 1'b0;
		redirect_pc <= 64'h0000000000000000;
		squash_next <= 1'b0;
		clear_instr_hazards <= 1'b0;
		superscalar_nop <= 1'b0;
		exc_cop_unusable <= 1'b0;
		exc_reserved <= 1'b0;
	end else begin
		op_done <= 1'b0;
		gpr_we <= 1'b0;
		redirect_valid <= 1'b0;
		squash_next <= 1'b0;
		clear_instr_hazards <= 1'b0;
		superscalar_nop <= 1'b0;
		exc_cop_unusable <= 1'b0;
		exc_reserved <= 1'b0;
		case (state)
			ST_IDLE: begin
				instr_ready <= 1'b1;
				if (take) begin
					op_done <= 1'b1;
					case (cls)
						`ERB_CLS_BARRIER: begin
							if (ARCH_REV == 4'h1) begin
								// [RULE_04] first release issue slot only
								superscalar_nop <= 1'b1;
							end else if (exec_hazard_busy) begin
								// [RULE_02] hold issue while hazards pend
								// [RULE_03] instruction hazards untouched
								op_done <= 1'b0;
								instr_ready <= 1'b0;
								state <= ST_WAIT;
							end
						end
						`ERB_CLS_IRQEN: begin
							if (ARCH_REV < 4'h2) begin
								// [RULE_07] reserved before release 2
								exc_reserved <= 1'b1;
							end else if (!cp0_usable) begin
								// [RULE_06] no cp0 access
								exc_cop_unusable <= 1'b1;
							end else begin
								// [RULE_05] old status sign-extended
								gpr_we <= (instr_word[20:16] != 5'h00);
								gpr_waddr <= instr_word[20:16];
								gpr_wdata <= {{32{status[31]}}, status};
							end
						end
						`ERB_CLS_RETURN, `ERB_CLS_RETURN_NC: begin
							if (!NOCLEAR_PRESENT && cls == `ERB_CLS_RETURN_NC) begin
								exc_reserved <= 1'b1;
							end else if (!cp0_usable) begin
								// [RULE_20] fault with no state change
								exc_cop_unusable <= 1'b1;
							end else begin
								// [RULE_10] redirect and drop the next word
								// [RULE_19] accepted in any slot on every release
								redirect_valid <= 1'b1;
								squash_next <= 1'b1;
								// [RULE_16] full hazard clear at target
								clear_instr_hazards <= 1'b1;
								// [RULE_14] pc with bit 0 forced low when bit 0 is a mode bit
								redirect_pc <= split_mode ? {ret_tgt[63:1], 1'b0} : ret_tgt;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_WAIT: begin
				// [RULE_02] release once hazards resolved
				if (!exec_hazard_busy) begin
					op_done <= 1'b1;
					instr_ready <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

// Interrupt enable is the status bit, registered one edge later for the core
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		global_irq_enable <= 1'b0;
	end else begin
		global_irq_enable <= status[`ERB_ST_IE];
	end
end

endmodule // erb_unit

//--- testbench/erb_unit_assertions.sv
`include "erb_defs.vh"
module erb_unit_chk #(
	parameter [3:0] ARCH_REV = 4'h6,
	parameter [0:0] NOCLEAR_PRESENT = 1'b1
) (
	input wire pclk,
	input wire presetn,
	input wire instr_valid,
	input wire [31:0] instr_word,
	input wire cp0_usable,
	input wire exec_hazard_busy,
	input wire load_linked,
	input wire store_conditional,
	input wire instr_ready,
	input wire op_done,
	input wire gpr_we,
	input wire redirect_valid,
	input wire [63:0] redirect_pc,
	input wire squash_next,
	input wire clear_instr_hazards,
	input wire superscalar_nop,
	input wire exc_cop_unusable,
	input wire exc_reserved,
	input wire global_irq_enable,
	input wire link_reservation_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// Words taken at this edge, by class; old releases handled apart
	wire tk = instr_valid & instr_ready;
	wire new_rev = (ARCH_REV >= 4'h2);
	wire ret = tk & (instr_word == `ERB_ENC_RETURN);
	wire rnc = tk & (instr_word == `ERB_ENC_RETURN_NC) & NOCLEAR_PRESENT;
	wire irq_any = tk & ((instr_word & `ERB_MASK_IRQEN) == `ERB_ENC_IRQEN);
	wire irq = irq_any & new_rev;
	wire bar_any = tk & (instr_word == `ERB_ENC_BARRIER);
	wire bar = bar_any & (ARCH_REV != 4'h1);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////
	a_ret_jump: assert property ((ret | rnc) && cp0_usable |=> redirect_valid && squash_next)
		else $error("return did not redirect");
	a_ret_clear: assert property ((ret | rnc) && cp0_usable |=> clear_instr_hazards)
		else $error("return left hazards");
	a_ret_link: assert property (ret && cp0_usable && !load_linked |=> !link_reservation_flag)
		else $error("reservation kept");
	a_nc_link: assert property (rnc && cp0_usable && !load_linked && !store_conditional
		|=> link_reservation_flag == $past(link_reservation_flag))
		else $error("reservation lost");
	a_cp0_fault: assert property ((ret | rnc | irq) && !cp0_usable
		|=> exc_cop_unusable && !redirect_valid && !gpr_we)
		else $error("no fault");
	a_irq_dest: assert property (irq && cp0_usable |=> gpr_we == ($past(instr_word[20:16]) != 5'h00))
		else $error("bad write enable");
	a_irq_set: assert property (irq && cp0_usable |=> ##1 global_irq_enable)
		else $error("enable not set");
	a_bar_hold: assert property (bar && exec_hazard_busy |=> !instr_ready && !op_done)
		else $error("barrier did not stall");
	a_bar_wait: assert property (!instr_ready && exec_hazard_busy |=> !op_done)
		else $error("barrier ended early");
	a_bar_go: assert property (bar && !exec_hazard_busy |=> op_done && !redirect_valid)
		else $error("barrier mishandled");
	a_pc_even: assert property (redirect_valid |-> !redirect_pc[0])
		else $error("odd target");
	a_old_nop: assert property (bar_any && (ARCH_REV == 4'h1) |=> superscalar_nop && op_done)
		else $error("first release barrier not a nop");
	a_old_irq: assert property (irq_any && !new_rev |=> exc_reserved && !gpr_we)
		else $error("old release irq enable not reserved");
	// Main scenarios reached
	c_ret: cover property (ret && cp0_usable);
	c_rnc: cover property (rnc && cp0_usable);
	c_bar: cover property (bar && exec_hazard_busy);
	c_old: cover property (bar_any && (ARCH_REV == 4'h1));
endmodule // erb_unit_chk
bind erb_unit erb_unit_chk #(.ARCH_REV(ARCH_REV), .NOCLEAR_PRESENT(NOCLEAR_PRESENT)) chk (.pclk, .presetn,
	.instr_valid, .instr_word, .cp0_usable, .exec_hazard_busy, .load_linked, .store_conditional, .instr_ready,
	.op_done, .gpr_we, .redirect_valid, .redirect_pc, .squash_next, .clear_instr_hazards, .superscalar_nop,
	.exc_cop_unusable, .exc_reserved, .global_irq_enable, .link_reservation_flag);

//--- testbench/erb_unit_tb.sv
`include "erb_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module erb_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// One case: status, word, target or gpr data, then status, shadow, state
	typedef struct {logic [31:0] st, w; logic [63:0] r; logic [31:0] es, esh, esw;} erb_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, iv = 0, cp0 = 1, busy = 0, ll = 0, se;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, iw = 32'h0, rd, prdata;
	logic pready, pslverr, irdy, done, rv, cu, xr;
	logic [63:0] wd, rpc;
	logic we, gie, old_nop, old_xr;
	logic [4:0] wa;
	int err_total = 0, n_checks = 0, cyc = 0;
	erb_row_t rows[5] = '{
		'{32'h0, 32'h0000577C, 64'h0, 32'h1, 32'h0C000140, 32'h2},
		'{32'h2, 32'h0003577C, 64'h2, 32'h3, 32'h0C000140, 32'h2},
		'{32'h4, `ERB_ENC_RETURN, 64'h2000, 32'h0, 32'h0C000140, 32'h0},
		'{32'h2, `ERB_ENC_RETURN, 64'h1000, 32'h0, 32'h0C000145, 32'h1},
		'{32'h400002, `ERB_ENC_RETURN_NC, 64'h1000, 32'h400000, 32'h0C000140, 32'h3}};
	erb_unit dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .instr_valid(iv), .instr_word(iw), .cp0_usable(cp0), .exec_hazard_busy(busy), .load_linked(ll),
		.store_conditional(1'b0), .instr_ready(irdy), .op_done(done), .gpr_we(we), .gpr_waddr(wa), .gpr_wdata(wd),
		.redirect_valid(rv), .redirect_pc(rpc), .squash_next(), .clear_instr_hazards(), .superscalar_nop(),
		.exc_cop_unusable(cu), .exc_reserved(xr), .global_irq_enable(gie), .instr_set_mode(),
		.link_reservation_flag());
	// First-release copy without the no-clear return, fed the same words
	erb_unit #(.ARCH_REV(4'h1), .NOCLEAR_PRESENT(1'b0)) dut_old (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .pstrb(4'hF), .prdata(), .pready(), .pslverr(), .instr_valid(iv), .instr_word(iw),
		.cp0_usable(cp0), .exec_hazard_busy(busy), .load_linked(ll), .store_conditional(1'b0), .instr_ready(),
		.op_done(), .gpr_we(), .gpr_waddr(), .gpr_wdata(), .redirect_valid(), .redirect_pc(), .squash_next(),
		.clear_instr_hazards(), .superscalar_nop(old_nop), .exc_cop_unusable(), .exc_reserved(old_xr),
		.global_irq_enable(), .instr_set_mode(), .link_reservation_flag());
	////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	// APB transfer; holds the request until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Offer one word, then wait for its completion or fault pulse
	task run(input logic [31:0] w);
		int k;
		k = 0;
		@(posedge pclk);
		iv <= 1;
		iw <= w;
		do @(posedge pclk); while (irdy !== 1'b1);
		iv <= 0;
		do begin
			@(posedge pclk);
			k++;
		end while ((done | cu | xr) !== 1'b1 && k < 40);
		if (k == 40) err_total++;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		// Reset values, config word, unmapped place
		apb(0, `ERB_ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h00400004)
		apb(0, `ERB_ADDR_CONFIG, 32'h0);
		`CHK(rd, 32'h00000136)
		apb(0, 8'h20, 32'h0);
		`CHK({se, rd}, 33'h100000000)
		$display("test done: reset");
		apb(1, `ERB_ADDR_RETPC_LO, 32'h1001);
		apb(1, `ERB_ADDR_RETPC_HI, 32'h0);
		apb(1, `ERB_ADDR_ERRPC_LO, 32'h2000);
		apb(1, `ERB_ADDR_ERRPC_HI, 32'h0);
		foreach (rows[i]) begin
			apb(1, `ERB_ADDR_STATUS, rows[i].st);
			apb(1, `ERB_ADDR_SHADOW, 32'h140);
			@(posedge pclk);
			ll <= 1;
			@(posedge pclk);
			ll <= 0;
			run(rows[i].w);
			`CHK((rows[i].w[15:12] == 4'h5) ? wd : rpc, rows[i].r)
			apb(0, `ERB_ADDR_STATUS, 32'h0);
			`CHK(rd, rows[i].es)
			apb(0, `ERB_ADDR_SHADOW, 32'h0);
			`CHK(rd, rows[i].esh)
			apb(0, `ERB_ADDR_STATE, 32'h0);
			`CHK(rd, rows[i].esw)
		end
		$display("test done: rows");
		// Return without coprocessor access leaves state alone
		cp0 <= 0;
		apb(1, `ERB_ADDR_STATUS, 32'h2);
		run(`ERB_ENC_RETURN);
		`CHK({cu, rv}, 2'b10)
		apb(0, `ERB_ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h2)
		cp0 <= 1;
		$display("test done: fault");
		// Barrier held off by pending hazards
		busy <= 1;
		fork
			run(`ERB_ENC_BARRIER);
			begin
				repeat (3) @(posedge pclk);
				`CHK(irdy, 1'b0)
				busy <= 0;
			end
		join
		`CHK(done, 1'b1)
		$display("test done: barrier");
		// Enable then barrier; the first-release copy answers beside it
		`CHK(gie, 1'b0)
		run(32'h0007577C);
		`CHK({we, wa, old_xr}, 7'b1001111)
		// software orders the enable with a barrier, not a count
		run(`ERB_ENC_BARRIER);
		`CHK({gie, old_nop}, 2'b11)
		run(`ERB_ENC_RETURN_NC);
		`CHK({rv, old_xr}, 2'b11)
		$display("test done: old release");
		print_verdict();
	end
endmodule // erb_unit_tb
